// *** core/ars_pkg.sv ***
// Purpose: constants and types for the ramp-time selection block
// Assumes: 100 MHz clk_sys, AHB-Lite word registers, 10 ms control tick
// Notes:   frequencies in 0.1 Hz units, ramp ticks of 10 ms
package ars_pkg;
    // timing
    localparam int CLK_NS   = 10;
    localparam int TICK_NS  = 10_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int DIV_CYC  = 34;
    // register byte offsets
    localparam logic [7:0] OFF_PAIR0    = 8'h00;
    localparam logic [7:0] OFF_UNIT     = 8'h20;
    localparam logic [7:0] OFF_SWFREQ   = 8'h24;
    localparam logic [7:0] OFF_ANASEL   = 8'h28;
    localparam logic [7:0] OFF_TERMFUNC = 8'h2C;
    localparam logic [7:0] OFF_TARGET   = 8'h30;
    localparam logic [7:0] OFF_MAXFREQ  = 8'h34;
    localparam logic [7:0] OFF_STATUS   = 8'h38;
    localparam logic [7:0] OFF_SCURVE0  = 8'h40;
    // field values and limits
    localparam logic [7:0]  FUNC_SEL1    = 8'h07;
    localparam logic [7:0]  FUNC_SEL2    = 8'h1A;
    localparam logic [3:0]  ANA_GAIN     = 4'h5;
    localparam logic [15:0] TIME_MAX     = 16'hEA60;
    localparam logic [7:0]  SCURVE_MAX   = 8'hFA;
    localparam int          UNIT_COARSE  = 10;
    localparam int          GAIN_SHIFT   = 12;
    // values after reset
    localparam logic        RST_UNIT     = 1'b1;
    localparam logic [15:0] RST_TIME     = 16'h0064;
    localparam logic [15:0] RST_SWFREQ   = 16'h0000;
    localparam logic [15:0] RST_MAXFREQ  = 16'h0258;
    localparam logic [7:0]  RST_SC_START = 8'h14;
    localparam logic [7:0]  RST_SC_END   = 8'h00;
    localparam logic [31:0] RST_TERMFUNC = 32'h0000_1A07;

    typedef struct packed {
        logic [15:0] accel;
        logic [15:0] decel;
    } ars_pair_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [1:0]  pair;
        logic        busy;
    } ars_stat_t;
endpackage : ars_pkg

// *** core/ars_ramp_select.sv ***
// Purpose: ramp pair selection and S-curve frequency reference generator
// Assumes: adcIn2 comes from a converter on clk_sys; terminals are raw pins
// Notes:   zero wait-state AHB-Lite slave, response always OKAY
`timescale 1ns/1ps
module ars_ramp_select #(
    parameter int TICK_CYCLES = ars_pkg::TICK_CYC,
    parameter int TERM_COUNT  = 4
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [TERM_COUNT-1:0] termIn,
    input  wire logic [11:0]           adcIn2,
    output logic      [15:0]           freqRef,
    output logic      [1:0]            pairActive,
    output logic                       rampBusy
);
    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // refuse shapes the divider schedule or the function word cannot serve
    if (TICK_CYCLES < 4 * ars_pkg::DIV_CYC) begin : g_chk_tick
        $error("TICK_CYCLES too small for the step divider");
    end
    if (TERM_COUNT < 1 || TERM_COUNT > 4) begin : g_chk_term
        $error("TERM_COUNT must be 1 to 4");
    end

    ars_pkg::ars_pair_t pairs [4];
    logic        unitSel;
    logic [15:0] switchFreq, freqTarget, maxFreq;
    logic [3:0]  anaFuncSel;
    logic [31:0] termFunc;
    logic [7:0]  scurve [4];
    logic [TERM_COUNT-1:0] termMeta, termSync;
    logic [TICK_W-1:0] tickCnt;
    logic        tick;
    logic [31:0] acc, stepNow, fullStep, jerkBegin, jerkEnd;
    logic        dirUp;
    logic        dValid, dWr;
    logic [7:0]  dAddr;

    // terminal pins cross into clk_sys before anything looks at them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            termMeta <= '0;
            termSync <= '0;
        end else begin
            termMeta <= termIn;
            termSync <= termMeta;
        end
    end

    // control tick, one pulse every TICK_CYCLES
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tickCnt <= TICK_LAST;
            tick    <= 1'b0;
        end else begin
            tickCnt <= (tickCnt == '0) ? TICK_LAST : tickCnt - 1'b1;
            tick    <= (tickCnt == '0);
        end
    end

    // terminal decode: any terminal set to a select function drives that bit
    logic [TERM_COUNT-1:0] hit1, hit2, use1, use2;
    for (genvar i = 0; i < TERM_COUNT; i++) begin : g_term
        assign use1[i] = termFunc[8*i +: 8] == ars_pkg::FUNC_SEL1;
        assign use2[i] = termFunc[8*i +: 8] == ars_pkg::FUNC_SEL2;
        assign hit1[i] = use1[i] & termSync[i];
        assign hit2[i] = use2[i] & termSync[i];
    end

    logic        termUsed, autoOn, accelerating, decelerating, gainOn;
    logic [1:0]  termPair, next_pair;
    logic [15:0] freqNow, tgtFreq;
    logic [31:0] tgtAcc;
    assign termUsed = (|use1) | (|use2);
    assign termPair = {|hit2, |hit1};
    assign autoOn   = switchFreq != 16'h0000;
    assign freqNow  = acc[31:16];
    assign tgtFreq  = (freqTarget > maxFreq) ? maxFreq : freqTarget;
    assign tgtAcc   = {tgtFreq, 16'h0000};
    assign accelerating = acc < tgtAcc;
    assign decelerating = acc > tgtAcc;

    // terminals win over the threshold; with neither, pair one stands
    always_comb begin
        if (termUsed) begin
            next_pair = termPair;
        end else if (autoOn && freqNow >= switchFreq) begin
            next_pair = 2'd0;
        end else if (autoOn) begin
            next_pair = 2'd3;
        end else begin
            next_pair = 2'd0;
        end
    end

    // pair changes only at a tick, the running reference is untouched
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pairActive <= 2'd0;
        end else if (tick) begin
            pairActive <= next_pair;
        end
    end

    // effective ramp length in ticks; gain applies to pair-one accel only
    logic [15:0] baseTime, effTime;
    logic [27:0] gainProd;
    logic [19:0] rampTicks, sBeginTicks, sEndTicks;
    assign baseTime = accelerating ? pairs[pairActive].accel : pairs[pairActive].decel;
    assign gainOn   = anaFuncSel == ars_pkg::ANA_GAIN && pairActive == 2'd0 && accelerating;
    assign gainProd = baseTime * adcIn2;
    assign effTime  = gainOn ? gainProd[27:ars_pkg::GAIN_SHIFT] : baseTime;
    assign rampTicks = unitSel ? 20'(effTime * ars_pkg::UNIT_COARSE) : {4'h0, effTime};
    assign sBeginTicks = {12'h000, accelerating ? scurve[0] : scurve[2]};
    assign sEndTicks   = {12'h000, accelerating ? scurve[1] : scurve[3]};

    // shared serial divider, cycles full step then both jerk figures
    logic [1:0]  divOp;
    logic [5:0]  divCnt;
    logic [31:0] divQuo;
    logic [20:0] divRem, remShift;
    logic [19:0] divDen, next_den;
    always_comb begin
        case (divOp)
            2'd0:    next_den = rampTicks;
            2'd1:    next_den = sBeginTicks;
            default: next_den = sEndTicks;
        endcase
        if (next_den == 20'h00000) begin
            next_den = 20'h00001;
        end
    end
    assign remShift = {divRem[19:0], divQuo[31]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divOp     <= 2'd0;
            divCnt    <= 6'd0;
            divQuo    <= 32'h0000_0000;
            divRem    <= 21'h00_0000;
            divDen    <= 20'h00001;
            fullStep  <= 32'h0000_0000;
            jerkBegin <= 32'h0000_0001;
            jerkEnd   <= 32'h0000_0001;
        end else if (divCnt == 6'd0) begin
            divQuo <= (divOp == 2'd0) ? {maxFreq, 16'h0000} : fullStep;
            divRem <= 21'h00_0000;
            divDen <= next_den;
            divCnt <= 6'd33;
        end else if (divCnt == 6'd1) begin
            // a zero jerk would stall the S segment forever
            case (divOp)
                2'd0:    fullStep  <= (divQuo == '0) ? 32'h0000_0001 : divQuo;
                2'd1:    jerkBegin <= (divQuo == '0) ? 32'h0000_0001 : divQuo;
                default: jerkEnd   <= (divQuo == '0) ? 32'h0000_0001 : divQuo;
            endcase
            divOp  <= (divOp == 2'd2) ? 2'd0 : divOp + 2'd1;
            divCnt <= 6'd0;
        end else begin
            divRem <= (remShift >= {1'b0, divDen}) ? remShift - {1'b0, divDen} : remShift;
            divQuo <= {divQuo[30:0], remShift >= {1'b0, divDen}};
            divCnt <= divCnt - 6'd1;
        end
    end

    // step shaping: linear rise over start time, linear fall near the end
    logic [31:0] remaining, baseStep, next_step;
    logic [32:0] stepSum;
    logic [51:0] brake;
    assign remaining = accelerating ? tgtAcc - acc : acc - tgtAcc;
    assign baseStep  = (dirUp != accelerating) ? 32'h0000_0000 : stepNow;
    assign stepSum   = {1'b0, baseStep} + {1'b0, jerkBegin};
    assign brake     = (baseStep * sEndTicks) >> 1;
    always_comb begin
        if (sEndTicks != 20'h00000 && {20'h00000, remaining} <= brake) begin
            next_step = (baseStep > jerkEnd) ? baseStep - jerkEnd : jerkEnd;
        end else if (sBeginTicks == 20'h00000) begin
            next_step = fullStep;
        end else if (stepSum > {1'b0, fullStep}) begin
            next_step = fullStep;
        end else begin
            next_step = stepSum[31:0];
        end
    end

    // reference moves one step per tick and lands exactly on target
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc      <= 32'h0000_0000;
            stepNow  <= 32'h0000_0000;
            dirUp    <= 1'b1;
            rampBusy <= 1'b0;
        end else if (tick) begin
            rampBusy <= accelerating | decelerating;
            dirUp    <= accelerating;
            if (!(accelerating | decelerating)) begin
                stepNow <= 32'h0000_0000;
            end else if (remaining <= next_step) begin
                acc     <= tgtAcc;
                stepNow <= next_step;
            end else begin
                acc     <= accelerating ? acc + next_step : acc - next_step;
                stepNow <= next_step;
            end
        end
    end
    assign freqRef = acc[31:16];

    // bus address phase capture; zero wait states so hreadyout stays high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dValid    <= 1'b0;
            dWr       <= 1'b0;
            dAddr     <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dValid    <= hsel && htrans[1] && hready;
            dWr       <= hwrite;
            dAddr     <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data prepared in address phase; unmapped reads return zero
    ars_pkg::ars_stat_t stat;
    assign stat = '{freq: acc[31:16], pair: pairActive, busy: rampBusy};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr[7:5] == 3'b000) begin
                hrdata <= {16'h0000, haddr[2] ? pairs[haddr[4:3]].decel : pairs[haddr[4:3]].accel};
            end else if (haddr[7:4] == ars_pkg::OFF_SCURVE0[7:4]) begin
                hrdata <= {24'h00_0000, scurve[haddr[3:2]]};
            end else begin
                case ({haddr[7:2], 2'b00})
                    ars_pkg::OFF_UNIT:     hrdata <= {31'h0000_0000, unitSel};
                    ars_pkg::OFF_SWFREQ:   hrdata <= {16'h0000, switchFreq};
                    ars_pkg::OFF_ANASEL:   hrdata <= {28'h000_0000, anaFuncSel};
                    ars_pkg::OFF_TERMFUNC: hrdata <= termFunc;
                    ars_pkg::OFF_TARGET:   hrdata <= {16'h0000, freqTarget};
                    ars_pkg::OFF_MAXFREQ:  hrdata <= {16'h0000, maxFreq};
                    ars_pkg::OFF_STATUS:   hrdata <= {13'h0000, stat};
                    default:               hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // register writes in data phase; out-of-range values clamp to the limit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 4; k++) begin
                pairs[k] <= '{accel: ars_pkg::RST_TIME, decel: ars_pkg::RST_TIME};
            end
            scurve[0]  <= ars_pkg::RST_SC_START;
            scurve[1]  <= ars_pkg::RST_SC_START;
            scurve[2]  <= ars_pkg::RST_SC_START;
            scurve[3]  <= ars_pkg::RST_SC_END;
            unitSel    <= ars_pkg::RST_UNIT;
            switchFreq <= ars_pkg::RST_SWFREQ;
            anaFuncSel <= 4'h0;
            termFunc   <= ars_pkg::RST_TERMFUNC;
            freqTarget <= 16'h0000;
            maxFreq    <= ars_pkg::RST_MAXFREQ;
        end else if (dValid && dWr) begin
            if (dAddr[7:5] == 3'b000) begin
                if (dAddr[2]) begin
                    pairs[dAddr[4:3]].decel <= (hwdata[15:0] > ars_pkg::TIME_MAX) ? ars_pkg::TIME_MAX : hwdata[15:0];
                end else begin
                    pairs[dAddr[4:3]].accel <= (hwdata[15:0] > ars_pkg::TIME_MAX) ? ars_pkg::TIME_MAX : hwdata[15:0];
                end
            end else if (dAddr[7:4] == ars_pkg::OFF_SCURVE0[7:4]) begin
                scurve[dAddr[3:2]] <= (hwdata[7:0] > ars_pkg::SCURVE_MAX) ? ars_pkg::SCURVE_MAX : hwdata[7:0];
            end else begin
                case ({dAddr[7:2], 2'b00})
                    ars_pkg::OFF_UNIT:     unitSel    <= hwdata[0];
                    ars_pkg::OFF_SWFREQ:   switchFreq <= hwdata[15:0];
                    ars_pkg::OFF_ANASEL:   anaFuncSel <= hwdata[3:0];
                    ars_pkg::OFF_TERMFUNC: termFunc   <= hwdata;
                    ars_pkg::OFF_TARGET:   freqTarget <= hwdata[15:0];
                    ars_pkg::OFF_MAXFREQ:  maxFreq    <= hwdata[15:0];
                    default:               unitSel    <= unitSel;
                endcase
            end
        end
    end

    // checks on selection, ramp motion and readback
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_term_prio: assert property (tick && termUsed |=> pairActive == $past(termPair))
        else $error("terminal selection not applied");
    a_auto_high: assert property (tick && !termUsed && autoOn && freqNow >= switchFreq |=> pairActive == 2'd0)
        else $error("auto switch above threshold not pair one");
    a_auto_low: assert property (tick && !termUsed && autoOn && freqNow < switchFreq |=> pairActive == 2'd3)
        else $error("auto switch below threshold not pair four");
    a_auto_off: assert property (tick && !termUsed && !autoOn |=> pairActive == 2'd0)
        else $error("auto switch active with zero threshold");
    a_freq_hold: assert property (!tick |=> $stable(acc) && $stable(pairActive))
        else $error("reference moved between ticks");
    a_ramp_up: assert property (tick && accelerating |=> acc > $past(acc) && acc <= $past(tgtAcc))
        else $error("accel step wrong");
    a_ramp_down: assert property (tick && decelerating |=> acc < $past(acc) && acc >= $past(tgtAcc))
        else $error("decel step wrong");
    a_step_start: assert property (tick && accelerating && !dirUp && sBeginTicks != 20'h00000
        && {20'h00000, remaining} > brake |=> stepNow <= $past(jerkBegin))
        else $error("S-curve start not from rest");
    a_unit_read: assert property (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ars_pkg::OFF_UNIT
        |=> hrdata == {31'h0000_0000, unitSel})
        else $error("unit readback wrong");

    c_pair_four: cover property (tick && pairActive == 2'd3 ##1 pairActive == 2'd0);
    c_gain_ramp: cover property (gainOn && tick);
    c_end_brake: cover property (tick && accelerating && stepNow != 32'h0000_0000 ##1 stepNow < $past(stepNow));
    c_reach_tgt: cover property (rampBusy ##1 !rampBusy);
endmodule : ars_ramp_select

// *** dv/ars_ramp_select_tb.sv ***
// Purpose: self-checking bench for the ramp pair selector
// Assumes: short control tick of TCK cycles, zero wait-state bus slave
// Notes:   ramp lengths are checked in ticks with a small alignment margin
`timescale 1ns/1ps
module ars_ramp_select_tb;
    localparam int TCK   = 150;
    localparam int LIMIT = 80000;
    logic        clk_sys     = 1'b0;
    logic        rst         = 1'b1;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0000_0000;
    logic [1:0]  htrans      = 2'b00;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'b010;
    logic [31:0] hwdata      = 32'h0000_0000;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic [3:0]  termIn;
    logic [11:0] adcIn2;
    logic [15:0] freqRef;
    logic [1:0]  pairActive;
    logic        rampBusy;
    logic [1:0]  selReq      = 2'b00;
    logic [11:0] gainReq     = 12'h000;
    logic [31:0] rd;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    ars_ramp_select #(.TICK_CYCLES(TCK), .TERM_COUNT(4)) DUT (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .termIn(termIn), .adcIn2(adcIn2),
        .freqRef(freqRef), .pairActive(pairActive), .rampBusy(rampBusy)
    );

    ars_term_ctrl #(.LAG(3)) partner (
        .clk_sys(clk_sys), .selReq(selReq), .gainReq(gainReq), .termIn(termIn), .adcIn2(adcIn2)
    );

    // free-running clock
    always #5 clk_sys = ~clk_sys;

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_near(input int got, input int exp, input int tol);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_near

    // one single word transfer; address held until hready, then data phase
    task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus_xfer

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        bus_xfer(a, 1'b0, 32'h0000_0000);
        check_val(rd, exp);
        check_val({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : reg_check

    // sampled on the falling edge so tick updates have landed
    task automatic pair_check(input logic [1:0] p);
        repeat (2 * TCK + 8) @(posedge clk_sys);
        @(negedge clk_sys);
        check_val({30'h0000_0000, pairActive}, {30'h0000_0000, p});
    endtask : pair_check

    // frequency must move one way only and arrive in about expTicks ticks
    task automatic ramp_to(input logic [15:0] tgt, input int expTicks);
        int          cyc;
        logic        up;
        logic [15:0] prev;
        up   = (tgt >= freqRef);
        prev = freqRef;
        cyc  = 0;
        bus_xfer(ars_pkg::OFF_TARGET, 1'b1, {16'h0000, tgt});
        while (freqRef !== tgt) begin
            @(negedge clk_sys);
            cyc++;
            check_val({31'h0000_0000, up ? freqRef < prev : freqRef > prev}, 32'h0000_0000);
            prev = freqRef;
        end
        check_near(cyc / TCK, expTicks, 2);
        repeat (2 * TCK) @(negedge clk_sys);
        check_val({31'h0000_0000, rampBusy}, 32'h0000_0000);
    endtask : ramp_to

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // values after reset, plus an unmapped hole
        for (int i = 0; i < 8; i++) begin
            reg_check(8'(4 * i), {16'h0000, ars_pkg::RST_TIME});
        end
        reg_check(ars_pkg::OFF_UNIT, 32'h0000_0001);
        reg_check(ars_pkg::OFF_SWFREQ, 32'h0000_0000);
        reg_check(ars_pkg::OFF_TERMFUNC, 32'h0000_1A07);
        reg_check(8'h3C, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            reg_check(ars_pkg::OFF_SCURVE0 + 8'(4 * i), i < 3 ? 32'h0000_0014 : 32'h0000_0000);
        end
        // writes beyond range clamp to the top value
        bus_xfer(ars_pkg::OFF_PAIR0, 1'b1, 32'h0000_FFFF);
        reg_check(ars_pkg::OFF_PAIR0, 32'h0000_EA60);
        bus_xfer(ars_pkg::OFF_SCURVE0, 1'b1, 32'h0000_01FF);
        reg_check(ars_pkg::OFF_SCURVE0, 32'h0000_00FA);
        // fine unit, no rounding, distinct accel time per pair
        bus_xfer(ars_pkg::OFF_UNIT, 1'b1, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            bus_xfer(ars_pkg::OFF_SCURVE0 + 8'(4 * i), 1'b1, 32'h0000_0000);
            bus_xfer(8'(8 * i), 1'b1, 32'(10 * (i + 1)));
            bus_xfer(8'(8 * i + 4), 1'b1, 32'h0000_000A);
        end
        for (int p = 0; p < 4; p++) begin
            selReq <= 2'(p);
            pair_check(2'(p));
            reg_check(ars_pkg::OFF_STATUS, 32'(2 * p));
            ramp_to(16'h0258, 10 * (p + 1));
            ramp_to(16'h0000, 10);
        end
        // rounding lengthens the ramps by half the rounding times
        selReq <= 2'b00;
        pair_check(2'b00);
        bus_xfer(ars_pkg::OFF_SCURVE0, 1'b1, 32'h0000_000A);
        bus_xfer(ars_pkg::OFF_SCURVE0 + 8'h04, 1'b1, 32'h0000_000A);
        ramp_to(16'h0258, 20);
        bus_xfer(ars_pkg::OFF_SCURVE0 + 8'h08, 1'b1, 32'h0000_000A);
        ramp_to(16'h0000, 15);
        // analog gain of one half on a 40 tick accel time
        bus_xfer(ars_pkg::OFF_SCURVE0, 1'b1, 32'h0000_0000);
        bus_xfer(ars_pkg::OFF_SCURVE0 + 8'h04, 1'b1, 32'h0000_0000);
        bus_xfer(ars_pkg::OFF_PAIR0, 1'b1, 32'h0000_0028);
        bus_xfer(ars_pkg::OFF_ANASEL, 1'b1, 32'h0000_0005);
        gainReq <= 12'h800;
        ramp_to(16'h0258, 20);
        ramp_to(16'h0000, 15);
        // coarse unit: three steps make 30 ticks
        bus_xfer(ars_pkg::OFF_ANASEL, 1'b1, 32'h0000_0000);
        bus_xfer(ars_pkg::OFF_UNIT, 1'b1, 32'h0000_0001);
        bus_xfer(ars_pkg::OFF_PAIR0, 1'b1, 32'h0000_0003);
        bus_xfer(ars_pkg::OFF_PAIR0 + 8'h04, 1'b1, 32'h0000_0001);
        ramp_to(16'h0258, 30);
        ramp_to(16'h0000, 15);
        // automatic switching with no terminal assigned; chattering pins ignored
        bus_xfer(ars_pkg::OFF_UNIT, 1'b1, 32'h0000_0000);
        bus_xfer(ars_pkg::OFF_SCURVE0 + 8'h08, 1'b1, 32'h0000_0000);
        bus_xfer(ars_pkg::OFF_TERMFUNC, 1'b1, 32'h0000_0000);
        selReq <= 2'b11;
        pair_check(2'b00);
        bus_xfer(ars_pkg::OFF_SWFREQ, 1'b1, 32'h0000_012C);
        pair_check(2'b11);
        ramp_to(16'h0258, 22);
        pair_check(2'b00);
        // terminals assigned again outrank the threshold below it
        bus_xfer(ars_pkg::OFF_TERMFUNC, 1'b1, 32'h0000_1A07);
        selReq <= 2'b00;
        ramp_to(16'h0000, 1);
        pair_check(2'b00);
        complete_run();
    end
endmodule : ars_ramp_select_tb

// *** dv/ars_term_ctrl.sv ***
// Purpose: external controller model driving the select terminals and analog input 2
// Assumes: terminal 0 carries function 7 and terminal 1 function 1A
// Notes:   pins change LAG+1 cycles after a request; unassigned pins chatter every cycle
`timescale 1ns/1ps
module ars_term_ctrl #(
    parameter int LAG = 3
) (
    input  wire logic        clk_sys,
    input  wire logic [1:0]  selReq,
    input  wire logic [11:0] gainReq,
    output logic      [3:0]  termIn,
    output logic      [11:0] adcIn2
);
    int          lagCnt  = 0;
    logic [1:0]  selPins = 2'b00;
    logic [1:0]  spare   = 2'b01;
    logic [11:0] level   = 12'h000;

    // spare pins have no function, so they toggle to expose any leak into selection
    assign termIn = {spare, selPins};
    assign adcIn2 = level;

    // relay contacts settle slowly; the device must not care how late they land
    always @(posedge clk_sys) begin
        spare <= ~spare;
        level <= gainReq;
        if (selReq == selPins) begin
            lagCnt <= 0;
        end else if (lagCnt == LAG) begin
            selPins <= selReq;
            lagCnt  <= 0;
        end else begin
            lagCnt <= lagCnt + 1;
        end
    end
endmodule : ars_term_ctrl
